// ===== logic/pgcfl_map.svh
`ifndef PGCFL_MAP_SVH
`define PGCFL_MAP_SVH
// Register byte addresses
`define PGCFL_OFF_CTRL      12'h000
`define PGCFL_OFF_FCL       12'h004
`define PGCFL_OFF_MPER      12'h008
`define PGCFL_OFF_OPER      12'h00c
`define PGCFL_OFF_MDUTY     12'h010
`define PGCFL_OFF_PDUTY     12'h014
`define PGCFL_OFF_SDUTY     12'h018
`define PGCFL_OFF_GLOBAL    12'h01c
`define PGCFL_OFF_STATUS    12'h020
// Generator control fields
`define PGCFL_B_FAULT_PENDING_FLAG     15
`define PGCFL_B_LIMSTAT     14
`define PGCFL_B_TRIGGER_PENDING_FLAG     13
`define PGCFL_B_FAULT_IRQ_ENABLE      12
`define PGCFL_B_LIMIEN      11
`define PGCFL_B_TRIGGER_IRQ_ENABLE      10
`define PGCFL_B_INDPER      9
`define PGCFL_B_MDUTY       8
`define PGCFL_B_CENTER      2
`define PGCFL_CTRL_WMASK    16'h1fff
// Fault / limit control fields
`define PGCFL_B_LIMPOL      9
`define PGCFL_B_LIMMOD      8
`define PGCFL_B_FLTPOL      2
`define PGCFL_FCL_RESET     16'h00f8
// Global control
`define PGCFL_B_GEN         15
// Status register fields
`define PGCFL_B_ST_CENTER   0
`define PGCFL_B_ST_LIMACT   1
`define PGCFL_B_ST_FLTACT   2
`define PGCFL_B_ST_PWM      3
`define PGCFL_B_ST_IRQ      4
`endif

// ===== logic/pgcfl_pkg.sv
package pgcfl_pkg;
    typedef enum logic [1:0] {PGCFL_UP, PGCFL_DOWN} pgcfl_dir_t;
endpackage

// ===== logic/pgcfl_counter.sv
`timescale 1ns/1ps
module pgcfl_counter #(
    parameter int W = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         run,
    input  wire logic         center,
    input  wire logic [W-1:0] period,
    input  wire logic [W-1:0] duty,
    output logic              pwm
);
    pgcfl_pkg::pgcfl_dir_t dir;
    pgcfl_pkg::pgcfl_dir_t next_dir;
    logic [W-1:0]          cnt;
    logic [W-1:0]          next_cnt;
    logic                  next_pwm;

    always_comb begin
        next_cnt = cnt;
        next_dir = dir;
        next_pwm = 1'b0;
        if (!run) begin
            next_cnt = '0;
            next_dir = pgcfl_pkg::PGCFL_UP;
        end else if (center) begin
            // Triangle count, so the pulse sits in the middle of the period
            case (dir)
                pgcfl_pkg::PGCFL_UP: begin
                    if (cnt >= period) begin
                        next_dir = pgcfl_pkg::PGCFL_DOWN;
                        next_cnt = cnt - W'(1);
                    end else begin
                        next_cnt = cnt + W'(1);
                    end
                end
                pgcfl_pkg::PGCFL_DOWN: begin
                    if (cnt == '0) begin
                        next_dir = pgcfl_pkg::PGCFL_UP;
                        next_cnt = W'(1);
                    end else begin
                        next_cnt = cnt - W'(1);
                    end
                end
                default: next_dir = pgcfl_pkg::PGCFL_UP;
            endcase
            next_pwm = cnt < duty;
        end else begin
            next_dir = pgcfl_pkg::PGCFL_UP;
            next_cnt = (cnt >= period) ? '0 : cnt + W'(1);
            next_pwm = cnt < duty;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt <= '0;
            dir <= pgcfl_pkg::PGCFL_UP;
            pwm <= 1'b0;
        end else begin
            cnt <= next_cnt;
            dir <= next_dir;
            pwm <= next_pwm;
        end
    end
endmodule // pgcfl_counter

// ===== logic/pgcfl_top.sv
`timescale 1ns/1ps
`include "pgcfl_map.svh"
module pgcfl_top #(
    parameter int W = 16
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fault_in,
    input  wire logic        limit_in,
    input  wire logic        trigger_in,
    output logic             pwm_high,
    output logic             pwm_low,
    output logic             fault_irq,
    output logic             limit_irq,
    output logic             trigger_irq
);
    logic [15:0] ctrl;
    logic [15:0] fcl;
    logic [15:0] mper;
    logic [15:0] oper;
    logic [15:0] mduty;
    logic [15:0] pduty;
    logic [15:0] sduty;
    logic        gen;
    logic [15:0] next_ctrl;
    logic [15:0] next_fcl;
    logic [15:0] next_mper;
    logic [15:0] next_oper;
    logic [15:0] next_mduty;
    logic [15:0] next_pduty;
    logic [15:0] next_sduty;
    logic        next_gen;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic        trg_prev;
    logic        fault_act;
    logic        limit_act;
    logic        trg_evt;
    logic        wr;
    logic        rd;
    logic        hit;
    logic        center_eff;
    logic [15:0] period_sel;
    logic [15:0] duty_h;
    logic [15:0] duty_l;
    logic        raw_h;
    logic        raw_l;
    logic        next_pwm_high;
    logic        next_pwm_low;
    logic        next_fault_irq;
    logic        next_limit_irq;
    logic        next_trigger_irq;

    // Pin inputs cross into core_clk
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1    <= '0;
            sync2    <= '0;
            trg_prev <= 1'b0;
        end else begin
            sync1    <= {trigger_in, limit_in, fault_in};
            sync2    <= sync1;
            trg_prev <= sync2[2];
        end
    end

    assign fault_act = sync2[0] ^ fcl[`PGCFL_B_FLTPOL];
    assign limit_act = ctrl_limit_on(fcl) & (sync2[1] ^ fcl[`PGCFL_B_LIMPOL]);
    assign trg_evt   = sync2[2] & ~trg_prev;

    function automatic logic ctrl_limit_on(input logic [15:0] f);
        return f[`PGCFL_B_LIMMOD];
    endfunction

    // Write commits on the edge where the master sees pready, never earlier
    assign wr = psel & penable & pwrite & pready;
    assign rd = psel & penable & ~pwrite & ~pready;

    always_comb begin
        hit = 1'b1;
        case (paddr)
            `PGCFL_OFF_CTRL, `PGCFL_OFF_FCL, `PGCFL_OFF_MPER, `PGCFL_OFF_OPER,
            `PGCFL_OFF_MDUTY, `PGCFL_OFF_PDUTY, `PGCFL_OFF_SDUTY,
            `PGCFL_OFF_GLOBAL, `PGCFL_OFF_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Register writes and hardware-set flags; a clear wins over a set, as the clearing write also drops the enable
    always_comb begin
        next_ctrl  = ctrl;
        next_fcl   = fcl;
        next_mper  = mper;
        next_oper  = oper;
        next_mduty = mduty;
        next_pduty = pduty;
        next_sduty = sduty;
        next_gen   = gen;
        if (wr) begin
            case (paddr)
                `PGCFL_OFF_CTRL: begin
                    next_ctrl = (pwdata[15:0] & `PGCFL_CTRL_WMASK) | (ctrl & ~`PGCFL_CTRL_WMASK);
                    if (!pwdata[`PGCFL_B_FAULT_IRQ_ENABLE]) next_ctrl[`PGCFL_B_FAULT_PENDING_FLAG] = 1'b0;
                    if (!pwdata[`PGCFL_B_LIMIEN]) next_ctrl[`PGCFL_B_LIMSTAT] = 1'b0;
                    if (!pwdata[`PGCFL_B_TRIGGER_IRQ_ENABLE]) next_ctrl[`PGCFL_B_TRIGGER_PENDING_FLAG] = 1'b0;
                end
                `PGCFL_OFF_FCL:    next_fcl   = pwdata[15:0];
                `PGCFL_OFF_MPER:   next_mper  = pwdata[15:0];
                `PGCFL_OFF_OPER:   next_oper  = pwdata[15:0];
                `PGCFL_OFF_MDUTY:  next_mduty = pwdata[15:0];
                `PGCFL_OFF_PDUTY:  next_pduty = pwdata[15:0];
                `PGCFL_OFF_SDUTY:  next_sduty = pwdata[15:0];
                `PGCFL_OFF_GLOBAL: next_gen   = pwdata[`PGCFL_B_GEN];
                default: next_gen = gen;
            endcase
        end
        // Flags set only while enabled, so a disabled flag stays clear
        if (fault_act && next_ctrl[`PGCFL_B_FAULT_IRQ_ENABLE]) next_ctrl[`PGCFL_B_FAULT_PENDING_FLAG] = 1'b1;
        if (limit_act && next_ctrl[`PGCFL_B_LIMIEN]) next_ctrl[`PGCFL_B_LIMSTAT] = 1'b1;
        if (trg_evt && next_ctrl[`PGCFL_B_TRIGGER_IRQ_ENABLE]) next_ctrl[`PGCFL_B_TRIGGER_PENDING_FLAG] = 1'b1;
    end

    always_comb begin
        next_prdata  = '0;
        next_pready  = psel & penable & ~pready;
        next_pslverr = psel & penable & ~pready & ~hit;
        if (rd) begin
            case (paddr)
                `PGCFL_OFF_CTRL:   next_prdata[15:0] = ctrl;
                `PGCFL_OFF_FCL:    next_prdata[15:0] = fcl;
                `PGCFL_OFF_MPER:   next_prdata[15:0] = mper;
                `PGCFL_OFF_OPER:   next_prdata[15:0] = oper;
                `PGCFL_OFF_MDUTY:  next_prdata[15:0] = mduty;
                `PGCFL_OFF_PDUTY:  next_prdata[15:0] = pduty;
                `PGCFL_OFF_SDUTY:  next_prdata[15:0] = sduty;
                `PGCFL_OFF_GLOBAL: next_prdata[`PGCFL_B_GEN] = gen;
                `PGCFL_OFF_STATUS: begin
                    next_prdata[`PGCFL_B_ST_CENTER] = center_eff;
                    next_prdata[`PGCFL_B_ST_LIMACT] = limit_act;
                    next_prdata[`PGCFL_B_ST_FLTACT] = fault_act;
                    next_prdata[`PGCFL_B_ST_PWM]    = pwm_high;
                    next_prdata[`PGCFL_B_ST_IRQ]    = fault_irq | limit_irq | trigger_irq;
                end
                default: next_prdata = '0;
            endcase
        end
    end

    // Time base and duty routing
    assign period_sel = ctrl[`PGCFL_B_INDPER] ? oper : mper;
    assign center_eff = ctrl[`PGCFL_B_INDPER] & ctrl[`PGCFL_B_CENTER];
    assign duty_h     = ctrl[`PGCFL_B_MDUTY] ? mduty : pduty;
    assign duty_l     = ctrl[`PGCFL_B_MDUTY] ? mduty : sduty;

    pgcfl_counter #(.W(16)) u_cnt_h (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .run      (gen),
        .center   (center_eff),
        .period   (period_sel),
        .duty     (duty_h),
        .pwm      (raw_h)
    );
    pgcfl_counter #(.W(16)) u_cnt_l (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .run      (gen),
        .center   (center_eff),
        .period   (period_sel),
        .duty     (duty_l),
        .pwm      (raw_l)
    );

    always_comb begin
        // Active fault or limit forces both outputs off, the safe state
        next_pwm_high    = raw_h & ~fault_act & ~limit_act;
        next_pwm_low     = raw_l & ~fault_act & ~limit_act;
        next_fault_irq   = next_ctrl[`PGCFL_B_FAULT_PENDING_FLAG] & next_ctrl[`PGCFL_B_FAULT_IRQ_ENABLE];
        next_limit_irq   = next_ctrl[`PGCFL_B_LIMSTAT] & next_ctrl[`PGCFL_B_LIMIEN];
        next_trigger_irq = next_ctrl[`PGCFL_B_TRIGGER_PENDING_FLAG] & next_ctrl[`PGCFL_B_TRIGGER_IRQ_ENABLE];
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl        <= '0;
            fcl         <= `PGCFL_FCL_RESET;
            mper        <= '0;
            oper        <= '0;
            mduty       <= '0;
            pduty       <= '0;
            sduty       <= '0;
            gen         <= 1'b0;
            prdata      <= '0;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            pwm_high    <= 1'b0;
            pwm_low     <= 1'b0;
            fault_irq   <= 1'b0;
            limit_irq   <= 1'b0;
            trigger_irq <= 1'b0;
        end else begin
            ctrl        <= next_ctrl;
            fcl         <= next_fcl;
            mper        <= next_mper;
            oper        <= next_oper;
            mduty       <= next_mduty;
            pduty       <= next_pduty;
            sduty       <= next_sduty;
            gen         <= next_gen;
            prdata      <= next_prdata;
            pready      <= next_pready;
            pslverr     <= next_pslverr;
            pwm_high    <= next_pwm_high;
            pwm_low     <= next_pwm_low;
            fault_irq   <= next_fault_irq;
            limit_irq   <= next_limit_irq;
            trigger_irq <= next_trigger_irq;
        end
    end

    a_irq_fault_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault_irq == (ctrl[`PGCFL_B_FAULT_PENDING_FLAG] & ctrl[`PGCFL_B_FAULT_IRQ_ENABLE]))
        else $error("fault irq not flag and enable");
    a_irq_trig_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
        trigger_irq == (ctrl[`PGCFL_B_TRIGGER_PENDING_FLAG] & ctrl[`PGCFL_B_TRIGGER_IRQ_ENABLE]))
        else $error("trigger irq not flag and enable");
    a_fault_clear_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr && paddr == `PGCFL_OFF_CTRL && !pwdata[`PGCFL_B_FAULT_IRQ_ENABLE] |=> !ctrl[`PGCFL_B_FAULT_PENDING_FLAG])
        else $error("fault flag not cleared");
    a_limit_clear_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr && paddr == `PGCFL_OFF_CTRL && !pwdata[`PGCFL_B_LIMIEN] |=> !ctrl[`PGCFL_B_LIMSTAT])
        else $error("limit flag not cleared");
    a_trig_clear_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr && paddr == `PGCFL_OFF_CTRL && !pwdata[`PGCFL_B_TRIGGER_IRQ_ENABLE] |=> !ctrl[`PGCFL_B_TRIGGER_PENDING_FLAG])
        else $error("trigger flag not cleared");
    a_trig_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        trg_evt && ctrl[`PGCFL_B_TRIGGER_IRQ_ENABLE] && !wr |=> ctrl[`PGCFL_B_TRIGGER_PENDING_FLAG] && trigger_irq)
        else $error("trigger event lost");
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl[`PGCFL_B_FAULT_PENDING_FLAG] && !wr |=> ctrl[`PGCFL_B_FAULT_PENDING_FLAG])
        else $error("fault flag dropped");
    a_center_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ctrl[`PGCFL_B_INDPER] |-> !center_eff)
        else $error("center active without independent period");
    a_period_route: assert property (@(posedge core_clk) disable iff (!rst_n)
        period_sel == (ctrl[`PGCFL_B_INDPER] ? oper : mper))
        else $error("period source wrong");
    a_limit_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        fcl[`PGCFL_B_LIMMOD] && (sync2[1] != fcl[`PGCFL_B_LIMPOL]) |=> !pwm_high && !pwm_low)
        else $error("limit did not force outputs off");
    a_apb_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not one cycle");
    a_fault_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault_act && ctrl[`PGCFL_B_FAULT_IRQ_ENABLE] && !wr |=> ctrl[`PGCFL_B_FAULT_PENDING_FLAG] && fault_irq)
        else $error("fault event lost");
    a_limit_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        limit_act && ctrl[`PGCFL_B_LIMIEN] && !wr |=> ctrl[`PGCFL_B_LIMSTAT] && limit_irq)
        else $error("limit event lost");
    a_flag_needs_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ctrl[`PGCFL_B_FAULT_PENDING_FLAG] || ctrl[`PGCFL_B_FAULT_IRQ_ENABLE])
        else $error("fault flag set while disabled");
    a_limit_mode_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        !fcl[`PGCFL_B_LIMMOD] && !fault_act && raw_h |=> pwm_high)
        else $error("limit blocked output with mode off");
    a_irq_limit_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
        limit_irq == (ctrl[`PGCFL_B_LIMSTAT] & ctrl[`PGCFL_B_LIMIEN]))
        else $error("limit irq not flag and enable");

    c_fault_irq: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(fault_irq));
    c_trig_irq: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(trigger_irq));
    c_center_run: cover property (@(posedge core_clk) disable iff (!rst_n) center_eff && gen);
    c_limit_hit: cover property (@(posedge core_clk) disable iff (!rst_n) limit_act && gen);
    c_limit_irq: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(limit_irq));
endmodule // pgcfl_top

// ===== sim/pgcfl_stage.sv
`timescale 1ns/1ps
module pgcfl_stage (
    input  wire logic core_clk,
    input  wire logic fault_cmd,
    input  wire logic limit_cmd,
    input  wire logic trig_cmd,
    output logic      fault_in,
    output logic      limit_in,
    output logic      trigger_in
);
    // Sense lines lag the command by one edge, like a slow comparator
    initial begin
        fault_in = 1'b0;
        limit_in = 1'b0;
        trigger_in = 1'b0;
    end

    always @(posedge core_clk) begin
        fault_in <= fault_cmd;
        limit_in <= limit_cmd;
        trigger_in <= trig_cmd;
    end
endmodule // pgcfl_stage

// ===== sim/pwm_gen_control_fault_limit_tb.sv
`timescale 1ns/1ps
`include "pgcfl_map.svh"
module pwm_gen_control_fault_limit_tb;
    logic        core_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fault_in;
    logic        limit_in;
    logic        trigger_in;
    logic        pwm_high;
    logic        pwm_low;
    logic        fault_irq;
    logic        limit_irq;
    logic        trigger_irq;
    logic [2:0]  cmd;
    int          num_errors;
    int          num_checks;
    int          hi;
    int          lo;

    pgcfl_top #(.W(16)) DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fault_in(fault_in), .limit_in(limit_in), .trigger_in(trigger_in),
        .pwm_high(pwm_high), .pwm_low(pwm_low), .fault_irq(fault_irq), .limit_irq(limit_irq),
        .trigger_irq(trigger_irq));

    pgcfl_stage stage (.core_clk(core_clk), .fault_cmd(cmd[2]), .limit_cmd(cmd[1]), .trig_cmd(cmd[0]),
        .fault_in(fault_in), .limit_in(limit_in), .trigger_in(trigger_in));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic complete_run;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; leaves one idle edge so psel is never reassigned in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {16'h0000, d}, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk_word(r & m, exp);
        chk_bit(e, a > `PGCFL_OFF_STATUS);
    endtask

    // Selects and polarities only change with the PWM stopped
    task automatic cfg(input logic [15:0] ctrl, input logic [15:0] fcl);
        wr(`PGCFL_OFF_GLOBAL, 16'h0000);
        wr(`PGCFL_OFF_CTRL, ctrl);
        wr(`PGCFL_OFF_FCL, fcl);
        wr(`PGCFL_OFF_GLOBAL, 16'h8000);
        repeat (10) @(posedge core_clk);
    endtask

    task automatic count_on;
        hi = 0;
        lo = 0;
        repeat (250) begin
            @(posedge core_clk);
            hi += (pwm_high === 1'b1);
            lo += (pwm_low === 1'b1);
        end
    endtask

    task automatic test_regs;
        rd(`PGCFL_OFF_CTRL, 32'hffff_ffff, 32'h0000_0000);
        rd(`PGCFL_OFF_FCL, 32'hffff_ffff, 32'h0000_00f8);
        rd(12'h0fc, 32'hffff_ffff, 32'h0000_0000);
        wr(`PGCFL_OFF_CTRL, 16'hffff);
        rd(`PGCFL_OFF_CTRL, 32'hffff_ffff, 32'h0000_1fff);
        wr(`PGCFL_OFF_CTRL, 16'h0000);
        $display("test_regs done");
    endtask

    task automatic test_period;
        wr(`PGCFL_OFF_MPER, 16'h0003);
        wr(`PGCFL_OFF_OPER, 16'h0064);
        wr(`PGCFL_OFF_MDUTY, 16'h0005);
        cfg(16'h0104, 16'h00f8);
        count_on;
        chk_word(hi, 250);
        rd(`PGCFL_OFF_STATUS, 32'h1, 32'h0);
        cfg(16'h0304, 16'h00f8);
        count_on;
        chk_bit(hi > 0 && hi < 250, 1'b1);
        rd(`PGCFL_OFF_STATUS, 32'h1, 32'h1);
        $display("test_period done");
    endtask

    task automatic test_duty;
        wr(`PGCFL_OFF_PDUTY, 16'h0000);
        wr(`PGCFL_OFF_SDUTY, 16'hffff);
        wr(`PGCFL_OFF_MDUTY, 16'hffff);
        cfg(16'h0200, 16'h00f8);
        count_on;
        chk_word(hi, 0);
        chk_word(lo, 250);
        cfg(16'h0300, 16'h00f8);
        count_on;
        chk_word(hi, 250);
        $display("test_duty done");
    endtask

    task automatic test_limit;
        cfg(16'h0300, 16'h01f8);
        cmd <= 3'b010;
        repeat (6) @(posedge core_clk);
        chk_bit(pwm_high, 1'b0);
        rd(`PGCFL_OFF_STATUS, 32'h2, 32'h2);
        cmd <= 3'b000;
        repeat (6) @(posedge core_clk);
        chk_bit(pwm_high, 1'b1);
        cfg(16'h0300, 16'h03f8);
        chk_bit(pwm_high, 1'b0);
        cmd <= 3'b010;
        repeat (6) @(posedge core_clk);
        chk_bit(pwm_high, 1'b1);
        cmd <= 3'b000;
        cfg(16'h0300, 16'h02f8);
        chk_bit(pwm_high, 1'b1);
        $display("test_limit done");
    endtask

    task automatic pulse(input int i);
        cmd <= 3'b100 >> i;
        repeat (6) @(posedge core_clk);
        cmd <= 3'b000;
        repeat (6) @(posedge core_clk);
    endtask

    // Order: fault, limit, trigger
    task automatic test_irq;
        wr(`PGCFL_OFF_GLOBAL, 16'h0000);
        wr(`PGCFL_OFF_FCL, 16'h01f8);
        for (int i = 0; i < 3; i++) begin
            wr(`PGCFL_OFF_CTRL, 16'h0000);
            pulse(i);
            rd(`PGCFL_OFF_CTRL, 32'hffff, 32'h0);
            wr(`PGCFL_OFF_CTRL, 16'h1000 >> i);
            pulse(i);
            rd(`PGCFL_OFF_CTRL, 32'hffff, (32'h9000 >> i));
            chk_word({29'h0, fault_irq, limit_irq, trigger_irq}, 32'h4 >> i);
            wr(`PGCFL_OFF_CTRL, 16'h0000);
            rd(`PGCFL_OFF_CTRL, 32'hffff, 32'h0);
            chk_word({29'h0, fault_irq, limit_irq, trigger_irq}, 32'h0);
        end
        $display("test_irq done");
    endtask

    initial begin
        #400000;
        num_errors++;
        complete_run;
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        cmd = 3'b000;
        num_errors = 0;
        num_checks = 0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        test_regs;
        test_period;
        test_duty;
        test_limit;
        test_irq;
        complete_run;
    end
endmodule // pwm_gen_control_fault_limit_tb
